/* hdl/oas_pkg.sv */
// Package for the optical acquisition sequencer: register map, fields, codes, timing.
package oas_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_SLOT = 8'h04;
  localparam logic [7:0] A_LRNG = 8'h08;
  localparam logic [7:0] A_LCUR = 8'h0C;
  localparam logic [7:0] A_STAT = 8'h10;
  localparam logic [7:0] A_FIFO = 8'h14;

  // ----------------------------------------------------------------
  // Control register fields and reset values
  // ----------------------------------------------------------------
  localparam int C_RUN   = 0;
  localparam int C_BURST = 1;
  localparam int C_RATE  = 2;
  localparam int C_PW    = 6;
  localparam int C_SET   = 8;
  localparam int C_BR    = 10;
  localparam int C_AVG   = 12;
  localparam int C_GPIO  = 20;
  localparam int C_AR1   = 22;
  localparam int C_AR2   = 24;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] SLOT_RST = 32'h0000_0000;
  localparam logic [31:0] LRNG_RST = 32'h0000_0000;
  localparam logic [31:0] LCUR_RST = 32'h0000_0000;
  localparam logic [1:0]  GPIO_EXT = 2'h2;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NSLOT      = 6;
  localparam int ADC_W      = 14;
  localparam int FIFO_DEPTH = 16;
  localparam int RATE_MAX   = 9;
  localparam int MIN_SPS    = 8;
  localparam int AVG_MAXSH  = 7;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ     = 100_000_000;
  localparam int CLK_NS     = 10;
  localparam int PW_NS  [4] = '{14_800, 29_400, 58_700, 117_300};
  localparam int SET_NS [4] = '{12_000, 8_000, 6_000, 4_000};
  localparam int BURST_HZ [4] = '{8, 32, 84, 256};

  // ----------------------------------------------------------------
  // Slot codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SL_NONE = 4'h0;
  localparam logic [3:0] SL_L1   = 4'h1;
  localparam logic [3:0] SL_L2   = 4'h2;
  localparam logic [3:0] SL_L3   = 4'h3;
  localparam logic [3:0] SL_L12  = 4'h4;
  localparam logic [3:0] SL_L13  = 4'h5;
  localparam logic [3:0] SL_L23  = 4'h6;
  localparam logic [3:0] SL_L123 = 4'h7;
  localparam logic [3:0] SL_L4   = 4'h8;
  localparam logic [3:0] SL_L5   = 4'h9;
  localparam logic [3:0] SL_L6   = 4'hA;
  localparam logic [3:0] SL_AMB  = 4'hB;

  typedef struct packed {
    logic [2:0]       slot;
    logic             pad;
    logic [ADC_W-1:0] ch2;
    logic [ADC_W-1:0] ch1;
  } oas_word_t;

  typedef enum logic [2:0] {S_IDLE, S_SCAN, S_SETTLE, S_INTEG, S_CAPT, S_PUSH} oas_state_t;

endpackage : oas_pkg

/* hdl/oas_sequencer.sv */
// Optical acquisition sequencer with AHB-Lite registers and result FIFO.
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------
// Result FIFO
// ----------------------------------------------------------------
module oas_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic                     clk,
  input  wire logic                     resetn,
  // Fill side
  input  wire logic                     in_valid,
  output logic                          in_ready,
  input  wire logic [W-1:0]             in_data,
  // Drain side
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [W-1:0]                  out_data,
  output logic [$clog2(DEPTH):0]        level
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  logic         do_w;
  logic         do_r;

  assign level     = wp - rp;
  assign in_ready  = (level != (AW+1)'(DEPTH));
  assign out_valid = (wp != rp);
  assign out_data  = mem[rp[AW-1:0]];
  assign do_w      = in_valid & in_ready;
  assign do_r      = out_valid & out_ready;

  always_ff @(posedge clk) begin
    if (do_w) begin
      mem[wp[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (do_w) begin
        wp <= wp + 1'b1;
      end
      if (do_r) begin
        rp <= rp + 1'b1;
      end
    end
  end
endmodule : oas_fifo

// ----------------------------------------------------------------
// Sequencer top
// ----------------------------------------------------------------
module oas_sequencer import oas_pkg::*; #(
  parameter int RATE_BASE_CYC = CLK_HZ / MIN_SPS,
  parameter int BURST_CYC [4] = '{CLK_HZ / BURST_HZ[0], CLK_HZ / BURST_HZ[1],
                                  CLK_HZ / BURST_HZ[2], CLK_HZ / BURST_HZ[3]},
  parameter int PW_CYC [4]    = '{(PW_NS[0] + CLK_NS - 1) / CLK_NS, (PW_NS[1] + CLK_NS - 1) / CLK_NS,
                                  (PW_NS[2] + CLK_NS - 1) / CLK_NS, (PW_NS[3] + CLK_NS - 1) / CLK_NS}
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // External sample trigger pin
  input  wire logic              ext_trigger,
  // Converter results, same clock
  input  wire logic [ADC_W-1:0]  adc_ch1,
  input  wire logic [ADC_W-1:0]  adc_ch2,
  // Optical front end control
  output logic [5:0]             led_on,
  output logic                   integrate,
  output logic [1:0]             adc_range_ch1,
  output logic [1:0]             adc_range_ch2,
  output logic [5:0]             led_range,
  output logic [23:0]            led_current
);
  localparam int SET_CYC [4] = '{(SET_NS[0] + CLK_NS - 1) / CLK_NS, (SET_NS[1] + CLK_NS - 1) / CLK_NS,
                                 (SET_NS[2] + CLK_NS - 1) / CLK_NS, (SET_NS[3] + CLK_NS - 1) / CLK_NS};
  localparam int AccW = ADC_W + AVG_MAXSH;

  // ----------------------------------------------------------------
  // Registers and bus slave
  // ----------------------------------------------------------------
  logic [31:0] ctrl;
  logic [31:0] slots;
  logic [31:0] lrng;
  logic [31:0] lcur;
  logic        wr_pend;
  logic [7:0]  wr_addr;
  logic        bus_req;
  logic        pop;
  logic [31:0] rd_mux;
  logic        fallback;
  oas_word_t   fifo_out;
  logic        fifo_out_valid;
  logic [4:0]  fifo_level;
  oas_state_t  state;
  logic        group_act;

  assign bus_req = hsel & hready & htrans[1];
  assign pop     = bus_req & ~hwrite & (haddr[7:0] == A_FIFO) & fifo_out_valid;

  always_comb begin
    unique case (haddr[7:0])
      A_CTRL:  rd_mux = ctrl;
      A_SLOT:  rd_mux = slots;
      A_LRNG:  rd_mux = lrng;
      A_LCUR:  rd_mux = lcur;
      A_STAT:  rd_mux = {24'h00_0000, group_act, (state != S_IDLE), 1'b0, fifo_level};
      A_FIFO:  rd_mux = fifo_out_valid ? fifo_out : 32'h0000_0000;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      wr_pend   <= 1'b0;
      wr_addr   <= 8'h00;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      wr_pend   <= bus_req & hwrite;
      if (bus_req) begin
        wr_addr <= haddr[7:0];
      end
      if (bus_req & ~hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  // Hardware clear of burst enable wins over a software write in the same cycle
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl  <= CTRL_RST;
      slots <= SLOT_RST;
      lrng  <= LRNG_RST;
      lcur  <= LCUR_RST;
    end else begin
      if (wr_pend) begin
        unique case (wr_addr)
          A_CTRL:  ctrl  <= {6'h00, hwdata[25:0]};
          A_SLOT:  slots <= {8'h00, hwdata[23:0]};
          A_LRNG:  lrng  <= {26'h000_0000, hwdata[5:0]};
          A_LCUR:  lcur  <= {8'h00, hwdata[23:0]};
          default: ;
        endcase
      end
      if (fallback) begin
        ctrl[C_BURST] <= 1'b0;
      end
    end
  end

  assign adc_range_ch1 = ctrl[C_AR1+:2];
  assign adc_range_ch2 = ctrl[C_AR2+:2];
  assign led_range     = lrng[5:0];
  assign led_current   = lcur[23:0];

  // ----------------------------------------------------------------
  // Derived settings
  // ----------------------------------------------------------------
  logic [3:0]  rate_code;
  logic [2:0]  avg_sh;
  logic [7:0]  avg_last;
  logic [15:0] rate_sps;
  logic [15:0] burst_need;
  logic [1:0]  br_sel;

  function automatic logic [2:0] shift_for(input logic [7:0] req);
    logic [2:0] s;
    s = 3'(AVG_MAXSH);
    for (int k = AVG_MAXSH; k >= 0; k--) begin
      if ((9'd1 << k) >= {1'b0, req}) begin
        s = 3'(k);
      end
    end
    return s;
  endfunction : shift_for

  assign rate_code  = (ctrl[C_RATE+:4] > 4'(RATE_MAX)) ? 4'(RATE_MAX) : ctrl[C_RATE+:4];
  assign rate_sps   = 16'(MIN_SPS) << rate_code;
  assign avg_sh     = shift_for(ctrl[C_AVG+:8]);
  assign avg_last   = 8'((9'd1 << avg_sh) - 9'd1);
  assign br_sel     = ctrl[C_BR+:2];
  assign burst_need = 16'(BURST_HZ[br_sel]) << avg_sh;
  assign fallback   = ctrl[C_BURST] & (burst_need > rate_sps);

  // ----------------------------------------------------------------
  // Rate dividers and external trigger
  // ----------------------------------------------------------------
  logic [23:0] conv_cnt;
  logic [23:0] burst_cnt;
  logic        conv_tick;
  logic        burst_tick;
  logic [2:0]  trig_sync;
  logic        sample_tick;
  logic        run;
  logic        burst_on;

  assign run      = ctrl[C_RUN];
  assign burst_on = ctrl[C_BURST] & ~fallback;

  always_ff @(posedge clk) begin
    if (!resetn || !run) begin
      conv_cnt  <= 24'h00_0000;
      conv_tick <= 1'b0;
    end else if (conv_cnt == 24'h00_0000) begin
      conv_cnt  <= 24'(RATE_BASE_CYC >> rate_code) - 24'h00_0001;
      conv_tick <= 1'b1;
    end else begin
      conv_cnt  <= conv_cnt - 24'h00_0001;
      conv_tick <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn || !run || !burst_on) begin
      burst_cnt  <= 24'h00_0000;
      burst_tick <= 1'b0;
    end else if (burst_cnt == 24'h00_0000) begin
      burst_cnt  <= 24'(BURST_CYC[br_sel]) - 24'h00_0001;
      burst_tick <= 1'b1;
    end else begin
      burst_cnt  <= burst_cnt - 24'h00_0001;
      burst_tick <= 1'b0;
    end
  end

  // Pin is asynchronous: two stages before the edge detector
  always_ff @(posedge clk) begin
    if (!resetn) begin
      trig_sync <= 3'h0;
    end else begin
      trig_sync <= {trig_sync[1:0], ext_trigger};
    end
  end

  assign sample_tick = (ctrl[C_GPIO+:2] == GPIO_EXT) ? (trig_sync[1] & ~trig_sync[2]) : conv_tick;

  // ----------------------------------------------------------------
  // Slot sequencer
  // ----------------------------------------------------------------
  logic [2:0]       slot_idx;
  logic [3:0]       slot_code;
  logic [7:0]       conv_idx;
  logic [16:0]      timer;
  logic [AccW-1:0]  acc1 [NSLOT];
  logic [AccW-1:0]  acc2 [NSLOT];
  logic [AccW-1:0]  sum1;
  logic [AccW-1:0]  sum2;
  logic             final_conv;
  oas_word_t        push_word;
  logic             fifo_in_ready;

  function automatic logic [5:0] led_map(input logic [3:0] c);
    unique case (c)
      SL_L1:   return 6'b00_0001;
      SL_L2:   return 6'b00_0010;
      SL_L3:   return 6'b00_0100;
      SL_L12:  return 6'b00_0011;
      SL_L13:  return 6'b00_0101;
      SL_L23:  return 6'b00_0110;
      SL_L123: return 6'b00_0111;
      SL_L4:   return 6'b00_1000;
      SL_L5:   return 6'b01_0000;
      SL_L6:   return 6'b10_0000;
      default: return 6'b00_0000;
    endcase
  endfunction : led_map

  assign slot_code  = slots[slot_idx*4+:4];
  assign sum1       = acc1[slot_idx] + AccW'(adc_ch1);
  assign sum2       = acc2[slot_idx] + AccW'(adc_ch2);
  assign final_conv = ~group_act | (conv_idx == avg_last);

  // Ticks that arrive while a conversion is under way are dropped
  always_ff @(posedge clk) begin
    if (!resetn || !run) begin
      state     <= S_IDLE;
      slot_idx  <= 3'h0;
      conv_idx  <= 8'h00;
      group_act <= 1'b0;
      timer     <= 17'h0_0000;
      led_on    <= 6'h00;
      integrate <= 1'b0;
      push_word <= '0;
      for (int i = 0; i < NSLOT; i++) begin
        acc1[i] <= '0;
        acc2[i] <= '0;
      end
    end else begin
      unique case (state)
        S_IDLE: begin
          slot_idx <= 3'h0;
          if (burst_on && !group_act && burst_tick) begin
            group_act <= 1'b1;
            conv_idx  <= 8'h00;
            state     <= S_SCAN;
          end else if (sample_tick && (group_act || !burst_on)) begin
            state <= S_SCAN;
          end
        end
        S_SCAN: begin
          if (slot_idx == 3'(NSLOT)) begin
            state <= S_IDLE;
            if (group_act) begin
              if (conv_idx == avg_last || !burst_on) begin
                group_act <= 1'b0;
              end
              conv_idx <= conv_idx + 8'h01;
            end
          end else if (slot_code == SL_NONE || slot_code > SL_AMB) begin
            slot_idx <= slot_idx + 3'h1;
          end else begin
            led_on <= led_map(slot_code);
            timer  <= 17'(SET_CYC[ctrl[C_SET+:2]]) - 17'h0_0001;
            state  <= S_SETTLE;
          end
        end
        S_SETTLE: begin
          if (timer == 17'h0_0000) begin
            integrate <= 1'b1;
            timer     <= 17'(PW_CYC[ctrl[C_PW+:2]]) - 17'h0_0001;
            state     <= S_INTEG;
          end else begin
            timer <= timer - 17'h0_0001;
          end
        end
        S_INTEG: begin
          if (timer == 17'h0_0000) begin
            integrate <= 1'b0;
            led_on    <= 6'h00;
            state     <= S_CAPT;
          end else begin
            timer <= timer - 17'h0_0001;
          end
        end
        S_CAPT: begin
          if (final_conv) begin
            push_word.slot <= slot_idx + 3'h1;
            push_word.pad  <= 1'b0;
            push_word.ch1  <= ADC_W'(sum1 >> avg_sh);
            push_word.ch2  <= ADC_W'(sum2 >> avg_sh);
            acc1[slot_idx] <= '0;
            acc2[slot_idx] <= '0;
            state          <= S_PUSH;
          end else begin
            acc1[slot_idx] <= sum1;
            acc2[slot_idx] <= sum2;
            slot_idx       <= slot_idx + 3'h1;
            state          <= S_SCAN;
          end
        end
        S_PUSH: begin
          if (fifo_in_ready) begin
            slot_idx <= slot_idx + 3'h1;
            state    <= S_SCAN;
          end
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Result FIFO; a full FIFO stalls the sequencer in the push state
  // ----------------------------------------------------------------
  oas_fifo #(
    .W     (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .resetn    (resetn),
    .in_valid  (state == S_PUSH),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (fifo_out_valid),
    .out_ready (pop),
    .out_data  (fifo_out),
    .level     (fifo_level)
  );

endmodule : oas_sequencer

`default_nettype wire

/* tb/oas_seq_props.sv */
// Concurrent checks on the sequencer's bus and front-end ports.
`timescale 1ns/1ps
`default_nettype none
module oas_seq_props import oas_pkg::*; #(
  parameter int PW_CYC [4] = '{20, 40, 80, 160}
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        resetn,
  // Bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // Front end
  input wire logic [5:0]  led_on,
  input wire logic        integrate
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  int lead_cnt;
  int wide_cnt;
  // Run lengths counted at the pins, so a wrong internal count shows where it ends
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lead_cnt <= 0;
    end else begin
      lead_cnt <= (led_on != 6'h00 && !integrate) ? lead_cnt + 1 : 0;
    end
  end
  always_ff @(posedge clk) begin
    if (!resetn) begin
      wide_cnt <= 0;
    end else begin
      wide_cnt <= integrate ? wide_cnt + 1 : 0;
    end
  end
  sequence s_int_end;
    integrate ##1 !integrate;
  endsequence
  sequence s_int_hold;
    integrate ##1 integrate;
  endsequence
  ready_high_a: assert property (hreadyout == 1'b1) else $error("bus wait state seen");
  resp_okay_a: assert property (hresp == 1'b0) else $error("bus error response seen");
  rdata_hold_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> $stable(hrdata))
    else $error("read data moved without a read");
  reset_quiet_a: assert property ($rose(resetn) |-> led_on == 6'h00 && !integrate && hrdata == 32'h0000_0000)
    else $error("outputs not cleared by reset");
  pulse_width_a: assert property ($fell(integrate) |-> wide_cnt == PW_CYC[0] || wide_cnt == PW_CYC[1] ||
    wide_cnt == PW_CYC[2] || wide_cnt == PW_CYC[3]) else $error("integration width not a legal setting");
  led_lead_a: assert property ($rose(integrate) && led_on != 6'h00 |-> lead_cnt inside {400, 600, 800, 1200})
    else $error("LED lead time not a legal setting");
  led_drop_a: assert property (s_int_end |-> led_on == 6'h00) else $error("LED still on after integration");
  led_steady_a: assert property (s_int_hold |-> $stable(led_on)) else $error("LED changed during integration");
endmodule : oas_seq_props
`default_nettype wire

/* tb/oas_host.sv */
// Host microcontroller model: single-word AHB-Lite master.
`timescale 1ns/1ps
`default_nettype none
module oas_host (
  // Clock
  input  wire logic        clk,
  // Master outputs
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata,
  // Slave answer
  input  wire logic        hready,
  input  wire logic [31:0] hrdata
);
  logic [31:0] rd_data;
  event        rd_done;
  initial begin
    hsel   = 1'b0;
    haddr  = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0000_0000;
  end
  // Caller enters just after a rising edge; each read is signalled to the bench's watcher
  task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {24'h00_0000, addr};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd_data = hrdata;
    hwdata <= ~wd;
    if (!wr) ->rd_done;
  endtask : xfer
endmodule : oas_host
`default_nettype wire

/* tb/test_oas_sequencer.sv */
// Self-checking bench for the optical acquisition sequencer.
`timescale 1ns/1ps
`default_nettype none
module test_oas_sequencer import oas_pkg::*; ;
  typedef struct {
    string       nm;
    logic [31:0] exp;
    logic [31:0] msk;
  } oas_note_t;
  logic              clk;
  logic              resetn;
  logic              hsel, hwrite, hreadyout, hresp, ext_trigger, integrate, int_d;
  logic [31:0]       haddr, hwdata, hrdata, v;
  logic [1:0]        htrans, adc_range_ch1, adc_range_ch2;
  logic [2:0]        hsize;
  logic [ADC_W-1:0]  adc_ch1, adc_ch2;
  logic [5:0]        led_on, led_range;
  logic [23:0]       led_current;
  oas_note_t         bus_q[$];
  logic [5:0]        led_q[$];
  int                miscompares, n_compared, n_expo, cycles, seed, e0, i;
  logic [7:0]        addr_l [7] = '{A_CTRL, A_SLOT, A_LRNG, A_LCUR, A_STAT, A_FIFO, 8'h18};
  logic [5:0]        led_l [5]  = '{6'h01, 6'h06, 6'h00, 6'h08, 6'h07};
  logic [2:0]        slot_l [5] = '{3'h1, 3'h3, 3'h4, 3'h5, 3'h6};

  oas_sequencer #(.RATE_BASE_CYC(4000), .BURST_CYC('{8000, 2000, 1000, 500}), .PW_CYC('{20, 40, 80, 160})) dut (
    .clk(clk), .resetn(resetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hready(hreadyout), .hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .ext_trigger(ext_trigger), .adc_ch1(adc_ch1), .adc_ch2(adc_ch2), .led_on(led_on), .integrate(integrate),
    .adc_range_ch1(adc_range_ch1), .adc_range_ch2(adc_range_ch2), .led_range(led_range),
    .led_current(led_current));
  oas_host host (.clk(clk), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata));

  // ----------------------------------------------------------------
  // Compare and report
  // ----------------------------------------------------------------
  task automatic cmp_read(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp_read
  task automatic cmp_port(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : cmp_port
  task automatic conclude();
    $display("Compared %0d, miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : conclude
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    bus_q.push_back('{nm, e, m});
    host.xfer(1'b0, a, 32'h0000_0000);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d);
  endtask : wr
  task automatic wait_expo(input int target);
    for (int t = 0; t < 20000 && n_expo < target; t++) @(posedge clk);
  endtask : wait_expo

  // ----------------------------------------------------------------
  // Clock, watchers, timeout
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial forever begin
    oas_note_t n;
    @(host.rd_done);
    n = bus_q.pop_front();
    cmp_read(n.nm, n.exp & n.msk, host.rd_data & n.msk);
  end
  always @(posedge clk) begin
    int_d <= integrate;
    if (integrate === 1'b1 && int_d === 1'b0) begin
      n_expo <= n_expo + 1;
      if (led_q.size() > 0) cmp_port("led_on", {26'h0, led_q.pop_front()}, {26'h0, led_on});
    end
  end
  // Generous ceiling: the whole run takes roughly half of it
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      conclude();
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    seed = 30959;
    resetn = 1'b0;
    ext_trigger = 1'b0;
    adc_ch1 = '0;
    adc_ch2 = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    foreach (addr_l[k]) rd("reset value", addr_l[k], 32'h0000_0000, 32'hFFFF_FFFF);
    wr(A_STAT, 32'hFFFF_FFFF);
    v = $random(seed);
    wr(A_CTRL, {6'h00, v[25:22], 22'h00_0000});
    wr(A_LRNG, {26'h0, v[5:0]});
    wr(A_LCUR, {8'h00, v[31:8]});
    rd("ctrl", A_CTRL, {6'h00, v[25:22], 22'h00_0000}, 32'hFFFF_FFFF);
    rd("lrng", A_LRNG, {26'h0, v[5:0]}, 32'hFFFF_FFFF);
    rd("lcur", A_LCUR, {8'h00, v[31:8]}, 32'hFFFF_FFFF);
    rd("status", A_STAT, 32'h0000_0000, 32'hFFFF_FFFF);
    cmp_port("adc_range", {28'h0, v[25:22]}, {28'h0, adc_range_ch2, adc_range_ch1});
    cmp_port("led_range", {26'h0, v[5:0]}, {26'h0, led_range});
    cmp_port("led_current", {8'h00, v[31:8]}, {8'h00, led_current});
    wr(A_CTRL, 32'h0008_0C03);
    repeat (3) @(posedge clk);
    rd("ctrl burst", A_CTRL, 32'h0008_0C01, 32'hFFFF_FFFF);
    wr(A_CTRL, 32'h0000_0000);
    v = $random(seed);
    adc_ch1 <= v[ADC_W-1:0];
    adc_ch2 <= v[ADC_W+15:16];
    wr(A_SLOT, 32'h0078_B601);
    for (i = 0; i < 16; i++) led_q.push_back(led_l[i % 5]);
    wr(A_CTRL, 32'h0000_030D);
    repeat (10000) @(posedge clk);
    rd("status full", A_STAT, 32'h0000_0050, 32'h0000_005F);
    wr(A_CTRL, 32'h0000_0000);
    for (i = 0; i < 16; i++) rd("fifo", A_FIFO, {slot_l[i % 5], 1'b0, adc_ch2, adc_ch1}, 32'hFFFF_FFFF);
    rd("fifo empty", A_FIFO, 32'h0000_0000, 32'hFFFF_FFFF);
    wr(A_SLOT, 32'h0000_0001);
    wr(A_CTRL, 32'h0000_3317);
    e0 = n_expo;
    wait_expo(e0 + 4);
    repeat (600) @(posedge clk);
    e0 = n_expo;
    repeat (4000) @(posedge clk);
    cmp_port("exposures", 32'h0000_0000, 32'(n_expo - e0));
    wait_expo(e0 + 4);
    repeat (600) @(posedge clk);
    rd("ctrl kept", A_CTRL, 32'h0000_3317, 32'hFFFF_FFFF);
    rd("status", A_STAT, 32'h0000_0002, 32'h0000_001F);
    wr(A_CTRL, 32'h0000_0000);
    repeat (2) rd("fifo avg", A_FIFO, {3'h1, 1'b0, adc_ch2, adc_ch1}, 32'hFFFF_FFFF);
    wr(A_CTRL, 32'h0020_0301);
    repeat (9000) @(posedge clk);
    rd("status no trig", A_STAT, 32'h0000_0000, 32'h0000_001F);
    ext_trigger <= 1'b1;
    repeat (3) @(posedge clk);
    ext_trigger <= 1'b0;
    repeat (800) @(posedge clk);
    rd("status trig", A_STAT, 32'h0000_0001, 32'h0000_001F);
    rd("fifo trig", A_FIFO, {3'h1, 1'b0, adc_ch2, adc_ch1}, 32'hFFFF_FFFF);
    wr(A_CTRL, 32'h0000_0000);
    conclude();
  end
endmodule : test_oas_sequencer

bind oas_sequencer oas_seq_props #(.PW_CYC(PW_CYC)) u_props (.clk(clk), .resetn(resetn), .hsel(hsel),
  .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .led_on(led_on), .integrate(integrate));
`default_nettype wire
